// >>> scm_mode_ctrl.sv
// control mode, loop switching and stop method decode for setup word one
// Function
// - mode 0,0: speed loop; multi-function input high or switch condition hit gives P, otherwise PI
// - mode 0,1: lock asserted and speed under threshold gives position lock
// - mode 1,0: torque loop only; multi-function and speed inputs ignored
// - mode 1,1: torque when input low, speed when input high
// - torque phase of mode 1,1: positive speed command is two-way limit
// - above the limit, retarding torque proportional to the excess
// - switch field: torque, speed, accel level, or none (factory 1,1)
// - PI to P switching applies only in speed control
// - bit F enables torque feed-forward; factory value 0
// - bit 5 set clears momentary stop alarm automatically and resumes
// - bit 6 set and bit 8 clear: brake relay off after stop
// - in torque control stop method follows bit 6 only
// - setup changes take effect only at next power-up
// - bit 6: 0 dynamic brake stop, 1 coast stop
// - bit 8 set: over-travel stop at emergency stop torque
`timescale 1ns/100ps
module scm_mode_ctrl
  import scm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // setup words as stored
  input wire logic [15:0] setup_word_one,
  input wire logic [15:0] setup_word_two,
  // host pins
  input wire logic multi_function_input,
  input wire logic signed [CMD_W-1:0] speed_command_input,
  input wire logic signed [CMD_W-1:0] torque_command_input,
  // motor state and levels
  input wire logic signed [CMD_W-1:0] motorSpeed,
  input wire logic signed [CMD_W-1:0] accelCommand,
  input wire logic [CMD_W-1:0] lock_speed_threshold,
  input wire logic [CMD_W-1:0] torque_switch_level,
  input wire logic [CMD_W-1:0] speed_switch_level,
  input wire logic [CMD_W-1:0] accel_switch_level,
  input wire logic signed [CMD_W-1:0] emergency_stop_torque,
  // events
  input wire logic momentaryStopAlarm,
  input wire logic motorStopped,
  input wire logic overTravel,
  input wire logic errorStop,
  // outputs
  output logic [3:0] activeLoop,
  output logic signed [CMD_W-1:0] torqueDemand,
  output logic signed [CMD_W-1:0] speedDemand,
  output logic feedForwardEnable,
  output logic alarmClear,
  output logic dynamicBrake,
  output logic coastOut,
  output logic internalSpeedMode
);
  import scm_pkg::*;

  scm_cfg_if cfg ();
  logic mfSync1, mfSync2;
  logic next_mfSync1, next_mfSync2;
  scm_loop_e next_loopState;
  logic signed [CMD_W-1:0] next_torqueDemand, next_speedDemand;
  logic next_feedForwardEnable, next_alarmClear, next_dynamicBrake, next_coastOut;
  logic next_internalSpeedMode;
  logic switchHit;
  logic signed [CMD_W:0] excess;

  function automatic logic [CMD_W-1:0] absVal(input logic signed [CMD_W-1:0] v);
    absVal = v[CMD_W-1] ? CMD_W'(-v) : v;
  endfunction

  scm_shadow shadow (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .setupWordOne(setup_word_one),
    .setupWordTwo(setup_word_two),
    .cfg(cfg.src)
  );

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_comb begin
    next_mfSync1 = multi_function_input;
    next_mfSync2 = mfSync1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mfSync1 <= 1'b0;
      mfSync2 <= 1'b0;
    end else begin
      mfSync1 <= next_mfSync1;
      mfSync2 <= next_mfSync2;
    end
  end

  // ****************************************
  // loop selection
  // ****************************************
  always_comb begin
    case (cfg.swCond)
      SW_TORQUE: switchHit = absVal(torque_command_input) > torque_switch_level;
      SW_SPEED: switchHit = absVal(speed_command_input) > speed_switch_level;
      SW_ACCEL: switchHit = absVal(accelCommand) > accel_switch_level;
      default: switchHit = 1'b0;
    endcase
    excess = {motorSpeed[CMD_W-1], motorSpeed};
    next_loopState = SCM_LOOP_PI;
    next_torqueDemand = torque_command_input;
    next_speedDemand = speed_command_input;
    if (cfg.internalSpeed) begin
      next_loopState = SCM_LOOP_PI;
    end else begin
      case (cfg.mode)
        MODE_SPEED: begin
          next_loopState = (mfSync2 || switchHit) ? SCM_LOOP_P : SCM_LOOP_PI;
        end
        MODE_LOCK: begin
          if (mfSync2 && absVal(motorSpeed) < lock_speed_threshold) begin
            next_loopState = SCM_LOOP_POS;
          end else begin
            next_loopState = switchHit ? SCM_LOOP_P : SCM_LOOP_PI;
          end
        end
        MODE_TORQUE_I: begin
          next_loopState = SCM_LOOP_TRQ;
          next_speedDemand = '0;
        end
        MODE_TORQUE_II: begin
          if (mfSync2) begin
            next_loopState = switchHit ? SCM_LOOP_P : SCM_LOOP_PI;
          end else begin
            next_loopState = SCM_LOOP_TRQ;
            if (!speed_command_input[CMD_W-1]) begin
              if (absVal(motorSpeed) > speed_command_input) begin
                excess = (CMD_W+1)'(absVal(motorSpeed)) - (CMD_W+1)'(speed_command_input);
                next_torqueDemand = motorSpeed[CMD_W-1] ? excess[CMD_W-1:0]
                                                        : CMD_W'(-excess);
              end
            end
          end
        end
        default: next_loopState = SCM_LOOP_PI;
      endcase
    end
    if (next_loopState != SCM_LOOP_TRQ) begin
      next_torqueDemand = '0;
    end
    // emergency stop torque only in the speed modes; torque modes stop by bit 6
    if (!cfg.mode[1] && overTravel && cfg.otTorque) begin
      next_torqueDemand = motorSpeed[CMD_W-1] ? emergency_stop_torque
                                              : CMD_W'(-emergency_stop_torque);
    end
    next_feedForwardEnable = cfg.feedFwd;
    next_alarmClear = cfg.alarmAuto && momentaryStopAlarm;
    next_internalSpeedMode = cfg.internalSpeed;
    // stop method
    next_coastOut = 1'b0;
    next_dynamicBrake = 1'b0;
    if (errorStop || (overTravel && (cfg.mode[1] || !cfg.otTorque))) begin
      next_coastOut = cfg.coastStop;
      next_dynamicBrake = !cfg.coastStop;
      if (motorStopped) begin
        next_dynamicBrake = (cfg.coastStop && !cfg.otTorque) ? 1'b0 : cfg.brakeHold;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      activeLoop <= SCM_LOOP_PI;
      torqueDemand <= '0;
      speedDemand <= '0;
      feedForwardEnable <= 1'b0;
      alarmClear <= 1'b0;
      dynamicBrake <= 1'b0;
      coastOut <= 1'b0;
      internalSpeedMode <= 1'b0;
    end else begin
      activeLoop <= next_loopState;
      torqueDemand <= next_torqueDemand;
      speedDemand <= next_speedDemand;
      feedForwardEnable <= next_feedForwardEnable;
      alarmClear <= next_alarmClear;
      dynamicBrake <= next_dynamicBrake;
      coastOut <= next_coastOut;
      internalSpeedMode <= next_internalSpeedMode;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  torque_one_only_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!cfg.internalSpeed && cfg.mode == MODE_TORQUE_I) |=> activeLoop == SCM_LOOP_TRQ)
    else $error("torque mode I left torque loop");
  speed_gain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!cfg.internalSpeed && cfg.mode == MODE_SPEED && mfSync2) |=> activeLoop == SCM_LOOP_P)
    else $error("gain reduction did not give P loop");
  lock_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!cfg.internalSpeed && cfg.mode == MODE_LOCK && mfSync2 &&
     absVal(motorSpeed) < lock_speed_threshold) |=> activeLoop == SCM_LOOP_POS)
    else $error("position lock not entered");
  torque_two_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!cfg.internalSpeed && cfg.mode == MODE_TORQUE_II && !mfSync2) |=> activeLoop == SCM_LOOP_TRQ)
    else $error("torque mode II select wrong");
  no_switch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!cfg.internalSpeed && cfg.mode == MODE_LOCK && cfg.swCond == SW_NONE && !mfSync2)
    |=> activeLoop == SCM_LOOP_PI) else $error("switch fired with none selected");
  feed_fwd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 feedForwardEnable == $past(cfg.feedFwd)) else $error("feed-forward mismatch");
  alarm_auto_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (momentaryStopAlarm && !cfg.alarmAuto) |=> !alarmClear)
    else $error("alarm cleared while disabled");
  coast_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (errorStop && cfg.coastStop && !cfg.otTorque && motorStopped) |=> !dynamicBrake && coastOut)
    else $error("brake relay held in coast stop");
  torque_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (overTravel && cfg.mode[1] && !cfg.coastStop && !motorStopped) |=> dynamicBrake)
    else $error("torque mode stop ignored bit 6");
endmodule

// >>> scm_pkg.sv
// package of constants and types for the servo control mode setup block
package scm_pkg;

  // ****************************************
  // setup word one field positions, plus the internal speed bit of setup word two
  // ****************************************
  localparam int ALARM_AUTO_BIT = 5;
  localparam int COAST_STOP_BIT = 6;
  localparam int BRAKE_HOLD_BIT = 7;
  localparam int OT_TORQUE_BIT = 8;
  localparam int MODE_LO_BIT = 10;
  localparam int MODE_HI_BIT = 11;
  localparam int SW_LO_BIT = 12;
  localparam int SW_HI_BIT = 13;
  localparam int ENC_ABS_BIT = 14;
  localparam int FEED_FWD_BIT = 15;
  localparam int WORD_TWO_INTERNAL_BIT = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] SETUP_ONE_RESET = 16'h30e0;
  localparam logic [15:0] SETUP_TWO_RESET = 16'h0000;

  // ****************************************
  // encodings and widths
  // ****************************************
  localparam int CMD_W = 16;
  localparam logic [1:0] MODE_SPEED = 2'h0;
  localparam logic [1:0] MODE_LOCK = 2'h1;
  localparam logic [1:0] MODE_TORQUE_I = 2'h2;
  localparam logic [1:0] MODE_TORQUE_II = 2'h3;
  localparam logic [1:0] SW_TORQUE = 2'h0;
  localparam logic [1:0] SW_SPEED = 2'h1;
  localparam logic [1:0] SW_ACCEL = 2'h2;
  localparam logic [1:0] SW_NONE = 2'h3;

  // active loop, one-hot
  typedef enum logic [3:0] {
    SCM_LOOP_PI = 4'h1,
    SCM_LOOP_P = 4'h2,
    SCM_LOOP_POS = 4'h4,
    SCM_LOOP_TRQ = 4'h8
  } scm_loop_e;

endpackage

// >>> scm_cfg_if.sv
// interface carrying the latched setup fields to the loop selector
`timescale 1ns/100ps
interface scm_cfg_if;
  logic [1:0] mode;
  logic [1:0] swCond;
  logic feedFwd;
  logic alarmAuto;
  logic coastStop;
  logic brakeHold;
  logic otTorque;
  logic internalSpeed;
  modport src (output mode, swCond, feedFwd, alarmAuto, coastStop, brakeHold, otTorque,
               internalSpeed);
  modport dst (input mode, swCond, feedFwd, alarmAuto, coastStop, brakeHold, otTorque,
               internalSpeed);
endinterface

// >>> scm_shadow.sv
// shadow copy of the setup words, captured once after power-up
`timescale 1ns/100ps
module scm_shadow
  import scm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // stored words
  input wire logic [15:0] setupWordOne,
  input wire logic [15:0] setupWordTwo,
  // latched fields
  scm_cfg_if.src cfg
);
  logic captured;
  logic next_captured;
  logic [15:0] shadowOne;
  logic [15:0] next_shadowOne;
  logic [15:0] shadowTwo;
  logic [15:0] next_shadowTwo;

  // ****************************************
  // one-shot capture
  // ****************************************
  always_comb begin
    next_captured = 1'b1;
    next_shadowOne = shadowOne;
    next_shadowTwo = shadowTwo;
    if (!captured) begin
      next_shadowOne = setupWordOne;
      next_shadowTwo = setupWordTwo;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      captured <= 1'b0;
      shadowOne <= SETUP_ONE_RESET;
      shadowTwo <= SETUP_TWO_RESET;
    end else begin
      captured <= next_captured;
      shadowOne <= next_shadowOne;
      shadowTwo <= next_shadowTwo;
    end
  end

  assign cfg.mode = shadowOne[MODE_HI_BIT:MODE_LO_BIT];
  assign cfg.swCond = shadowOne[SW_HI_BIT:SW_LO_BIT];
  assign cfg.feedFwd = shadowOne[FEED_FWD_BIT];
  assign cfg.alarmAuto = shadowOne[ALARM_AUTO_BIT];
  assign cfg.coastStop = shadowOne[COAST_STOP_BIT];
  assign cfg.brakeHold = shadowOne[BRAKE_HOLD_BIT];
  assign cfg.otTorque = shadowOne[OT_TORQUE_BIT];
  assign cfg.internalSpeed = shadowTwo[WORD_TWO_INTERNAL_BIT];

  shadow_frozen_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    captured |=> $stable(shadowOne)) else $error("shadow word changed after capture");
endmodule

// >>> scm_host_model.sv
// host motion controller model driving the analog commands, the pin and the motor events
`timescale 1ns/100ps
module scm_host_model (
  // clock
  input wire logic ref_clk,
  // analog commands and pin
  output logic multi_function_input,
  output logic signed [scm_pkg::CMD_W-1:0] speed_command_input,
  output logic signed [scm_pkg::CMD_W-1:0] torque_command_input,
  // motor feedback
  output logic signed [scm_pkg::CMD_W-1:0] motorSpeed,
  output logic signed [scm_pkg::CMD_W-1:0] accelCommand,
  // events: alarm, stopped, over-travel, error
  output logic [3:0] motorEvents
);
  import scm_pkg::*;

  initial begin
    multi_function_input = 1'b0;
    speed_command_input = 16'h0000;
    torque_command_input = 16'h0000;
    motorSpeed = 16'h0000;
    accelCommand = 16'h0000;
    motorEvents = 4'h0;
  end

  // new levels land just after an edge and then stand
  task automatic drive(input logic m, input logic [15:0] s, input logic [15:0] t,
                       input logic [15:0] v, input logic [15:0] a, input logic [3:0] e);
    @(posedge ref_clk);
    #2;
    multi_function_input = m;
    speed_command_input = s;
    torque_command_input = t;
    motorSpeed = v;
    accelCommand = a;
    motorEvents = e;
  endtask
endmodule

// >>> tb_servo_control_mode_setup.sv
// testbench for the servo control mode setup block
`timescale 1ns/100ps
module tb_servo_control_mode_setup;
  import scm_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] wordOne = SETUP_ONE_RESET;
  logic [15:0] wordTwo = SETUP_TWO_RESET;
  logic [15:0] level = 16'h0064;
  logic signed [CMD_W-1:0] stopTrq = 16'h0200;
  logic mfi;
  logic signed [CMD_W-1:0] spdCmd, trqCmd, motSpd, accCmd, torqueDemand, speedDemand;
  logic [3:0] ev;
  logic [3:0] activeLoop;
  logic ffEn, alarmClr, dynBrake, coast, intSpd;
  int n_fail = 0;
  int compares = 0;

  scm_host_model scm_host_model_inst (.ref_clk(ref_clk), .multi_function_input(mfi),
    .speed_command_input(spdCmd), .torque_command_input(trqCmd), .motorSpeed(motSpd),
    .accelCommand(accCmd), .motorEvents(ev));

  scm_mode_ctrl scm_mode_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .setup_word_one(wordOne), .setup_word_two(wordTwo), .multi_function_input(mfi),
    .speed_command_input(spdCmd), .torque_command_input(trqCmd), .motorSpeed(motSpd),
    .accelCommand(accCmd), .lock_speed_threshold(level), .torque_switch_level(level),
    .speed_switch_level(level), .accel_switch_level(level), .emergency_stop_torque(stopTrq),
    .momentaryStopAlarm(ev[0]), .motorStopped(ev[1]), .overTravel(ev[2]), .errorStop(ev[3]),
    .activeLoop(activeLoop), .torqueDemand(torqueDemand), .speedDemand(speedDemand),
    .feedForwardEnable(ffEn), .alarmClear(alarmClr), .dynamicBrake(dynBrake),
    .coastOut(coast), .internalSpeedMode(intSpd));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // access and check tasks
  // ****************************************
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chkBit(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic chkLoop(input scm_loop_e exp);
    chk("activeLoop", {12'h000, exp}, {12'h000, activeLoop});
  endtask

  // setup words are stored while power is off, then taken at power-up
  task automatic power_up(input logic [15:0] w1, input logic [15:0] w2);
    @(posedge ref_clk);
    #2;
    sys_rst = 1'b1;
    wordOne = w1 & 16'hbfff;
    wordTwo = w2;
    repeat (6) @(posedge ref_clk);
    #2;
    sys_rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
  endtask

  task automatic run(input logic m, input logic [15:0] s, input logic [15:0] t,
                     input logic [15:0] v, input logic [15:0] a, input logic [3:0] e);
    scm_host_model_inst.drive(m, s, t, v, a, e);
    repeat (5) @(posedge ref_clk);
    #2;
  endtask

  function automatic logic [15:0] mk(input logic [1:0] m, input logic [1:0] s,
                                     input logic [15:0] x);
    mk = 16'h00e0 | x;
    mk[MODE_HI_BIT:MODE_LO_BIT] = m;
    mk[SW_HI_BIT:SW_LO_BIT] = s;
  endfunction

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    logic [15:0] x;
    power_up(mk(MODE_SPEED, SW_NONE, 16'h0000), 16'h0000);
    run(1'b1, 16'h01f4, 16'h01f4, 16'h0000, 16'h01f4, 4'h0);
    chkLoop(SCM_LOOP_P);
    chk("speedDemand", 16'h01f4, speedDemand);
    chkBit("feedForwardEnable", 1'b0, ffEn);
    run(1'b0, 16'h01f4, 16'h01f4, 16'h0000, 16'h01f4, 4'h0);
    chkLoop(SCM_LOOP_PI);
    wordOne = mk(MODE_TORQUE_I, SW_NONE, 16'h0000);
    run(1'b1, 16'h01f4, 16'h0000, 16'h0000, 16'h0000, 4'h0);
    chkLoop(SCM_LOOP_P);
    for (int s = 0; s < 3; s++) begin
      power_up(mk(MODE_SPEED, 2'(s), 16'h0000), 16'h0000);
      for (int k = 0; k < 2; k++) begin
        x = (k == 0) ? 16'h00c8 : 16'h0032;
        run(1'b0, (s == 1) ? x : 16'h0000, (s == 0) ? x : 16'h0000, 16'h0000,
            (s == 2) ? x : 16'h0000, 4'h0);
        chkLoop((k == 0) ? SCM_LOOP_P : SCM_LOOP_PI);
      end
    end
    power_up(mk(MODE_LOCK, SW_NONE, 16'h0000), 16'h0000);
    run(1'b1, 16'h0000, 16'h0000, 16'h0032, 16'h0000, 4'h0);
    chkLoop(SCM_LOOP_POS);
    run(1'b1, 16'h0000, 16'h0000, 16'h012c, 16'h0000, 4'h0);
    chkLoop(SCM_LOOP_PI);
    power_up(mk(MODE_TORQUE_I, SW_TORQUE, 16'h0000), 16'h0000);
    run(1'b1, 16'h01f4, 16'h012c, 16'h0000, 16'h0000, 4'h0);
    chkLoop(SCM_LOOP_TRQ);
    chk("torqueDemand", 16'h012c, torqueDemand);
    chk("speedDemand", 16'h0000, speedDemand);
    power_up(mk(MODE_TORQUE_II, SW_NONE, 16'h0000), 16'h0000);
    run(1'b0, 16'h0064, 16'h012c, 16'h0032, 16'h0000, 4'h0);
    chkLoop(SCM_LOOP_TRQ);
    chk("torqueDemand", 16'h012c, torqueDemand);
    run(1'b0, 16'h0064, 16'h012c, 16'h0096, 16'h0000, 4'h0);
    chkBit("torqueDemand sign", 1'b1, torqueDemand[15]);
    run(1'b0, 16'h0064, 16'hfed4, 16'hff6a, 16'h0000, 4'h0);
    chkBit("torqueDemand sign", 1'b0, torqueDemand[15]);
    run(1'b1, 16'h0064, 16'h012c, 16'h0032, 16'h0000, 4'h0);
    chkLoop(SCM_LOOP_PI);
    power_up(mk(MODE_SPEED, SW_NONE, 16'h8000), 16'h0004);
    chkBit("feedForwardEnable", 1'b1, ffEn);
    chkBit("internalSpeedMode", 1'b1, intSpd);
    run(1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h1);
    chkLoop(SCM_LOOP_PI);
    chkBit("alarmClear", 1'b1, alarmClr);
    run(1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h8);
    chkBit("coastOut", 1'b1, coast);
    run(1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'ha);
    chkBit("dynamicBrake", 1'b0, dynBrake);
    power_up(mk(MODE_SPEED, SW_NONE, 16'h0100) & 16'hff9f, 16'h0000);
    run(1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h1);
    chkBit("alarmClear", 1'b0, alarmClr);
    run(1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h8);
    chkBit("coastOut", 1'b0, coast);
    chkBit("dynamicBrake", 1'b1, dynBrake);
    run(1'b0, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 4'h4);
    chk("torqueDemand", 16'hfe00, torqueDemand);
    power_up(mk(MODE_TORQUE_I, SW_NONE, 16'h0100) & 16'hffbf, 16'h0000);
    run(1'b0, 16'h0000, 16'h012c, 16'h0064, 16'h0000, 4'h4);
    chk("torqueDemand", 16'h012c, torqueDemand);
    chkBit("dynamicBrake", 1'b1, dynBrake);
    complete_run();
  end

  // cut a hang short well beyond the roughly 230 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
endmodule
